// ---- hdl/lbt_bank.sv ----
/*
 * lbt_bank: state machine and interval timer of one bank.
 * Assumes the tracker only sends commands that are legal for the
 * current state; protected intervals are never interrupted here.
 */
`timescale 1ns/10ps
module lbt_bank import lbt_pkg::*; (
   input  wire logic   clk,
   input  wire logic   rst,
   lbt_bank_if.bank    bif
);

   lbt_bank_state_type state_q;
   lbt_bank_state_type state_d;
   logic [CNT_W-1:0]   cnt_q;
   logic [CNT_W-1:0]   cnt_d;

   // ---------------------------------------------------------------
   // next state: timed exits first, then the new command
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end
      case (state_q)
         BS_ACTIVATING: begin
            if (cnt_q == '0) state_d = BS_ACTIVE;
         end
         BS_PRECHARGING, BS_READ_AP, BS_WRITE_AP: begin
            if (cnt_q == '0) state_d = BS_IDLE;
         end
         default: ;
      endcase
      case (bif.cmd)
         BC_ACT: begin
            state_d = BS_ACTIVATING;
            cnt_d   = RCD_LD;
         end
         BC_RD:  state_d = BS_READING;
         BC_WR:  state_d = BS_WRITING;
         BC_RDA: begin
            state_d = BS_READ_AP;
            cnt_d   = RP_LD;
         end
         BC_WRA: begin
            state_d = BS_WRITE_AP;
            cnt_d   = RP_LD;
         end
         BC_PRE: begin
            // idle banks restart tRP too
            state_d = BS_PRECHARGING;
            cnt_d   = RP_LD;
         end
         BC_END: begin
            // auto-precharge bursts keep their own timer
            if (state_q == BS_READING || state_q == BS_WRITING) begin
               state_d = BS_ACTIVE;
            end
         end
         BC_CLEAR: begin
            state_d = BS_IDLE;
            cnt_d   = '0;
         end
         default: ;
      endcase
   end

   // registers
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= BS_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   assign bif.state = state_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   localparam int A_RP  = RP_CYC;
   localparam int A_RCD = RCD_CYC;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_pre_ends_idle;
      (bif.cmd == BC_PRE) |=> (state_q == BS_PRECHARGING) ##A_RP (state_q == BS_IDLE);
   endproperty
   a_pre_ends_idle: assert property (p_pre_ends_idle) else $error("precharge interval wrong");

   property p_act_ends_active;
      (bif.cmd == BC_ACT) |=> (state_q == BS_ACTIVATING) ##A_RCD (state_q == BS_ACTIVE);
   endproperty
   a_act_ends_active: assert property (p_act_ends_active) else $error("activate wrong");

   property p_rda_ends_idle;
      (bif.cmd == BC_RDA) |=> (state_q == BS_READ_AP) ##A_RP (state_q == BS_IDLE);
   endproperty
   a_rda_ends_idle: assert property (p_rda_ends_idle) else $error("read ap wrong");

   property p_wra_ends_idle;
      (bif.cmd == BC_WRA) |=> (state_q == BS_WRITE_AP) ##A_RP (state_q == BS_IDLE);
   endproperty
   a_wra_ends_idle: assert property (p_wra_ends_idle) else $error("write ap wrong");

   property p_pre_on_idle;
      (bif.cmd == BC_PRE && state_q == BS_IDLE)
         |=> (state_q == BS_PRECHARGING && cnt_q == RP_LD);
   endproperty
   a_pre_on_idle: assert property (p_pre_on_idle) else $error("idle precharge skipped");

   property p_rd_plain;
      (bif.cmd == BC_RD || bif.cmd == BC_WR) |=> (state_q inside {BS_READING, BS_WRITING});
   endproperty
   a_rd_plain: assert property (p_rd_plain) else $error("plain burst state wrong");

endmodule

// ---- hdl/lbt_bank_if.sv ----
/*
 * lbt_bank_if: per-bank command and state between tracker and bank.
 * Assumes the tracker drives cmd for one cycle per decoded command.
 */
`timescale 1ns/10ps
interface lbt_bank_if import lbt_pkg::*; ();
   lbt_bank_cmd_type   cmd;
   lbt_bank_state_type state;

   modport ctrl (output cmd, input state);
   modport bank (input cmd, output state);
endinterface

// ---- hdl/lbt_pkg.sv ----
/*
 * lbt_pkg: constants, timing counts and enumerations for the LPDDR2
 * bank state tracker.
 * Assumes one core clock at CLK_PERIOD_NS; all timed intervals are
 * counted in whole cycles of that clock.
 */
package lbt_pkg;

   // ---------------------------------------------------------------
   // geometry
   // ---------------------------------------------------------------
   localparam int NUM_BANKS = 8;
   localparam int BANK_W    = 3;
   localparam int MA_W      = 8;
   localparam int CNT_W     = 8;
   localparam int BS_W      = 3;

   // ---------------------------------------------------------------
   // timing, printed figures in ns, counts derived
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int T_RP_NS       = 90;
   localparam int T_RCD_NS      = 90;
   localparam int T_MRR_NS      = 100;
   localparam int T_MRW_NS      = 250;
   localparam int T_BURST_NS    = 200;
   localparam int T_INIT_NS     = 10000;

   // least times round up, never below one cycle
   function automatic int cyc_up(input int t_ns);
      int c;
      c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int RP_CYC    = cyc_up(T_RP_NS);
   localparam int RCD_CYC   = cyc_up(T_RCD_NS);
   localparam int MRR_CYC   = cyc_up(T_MRR_NS);
   localparam int MRW_CYC   = cyc_up(T_MRW_NS);
   localparam int BURST_CYC = cyc_up(T_BURST_NS);
   localparam int INIT_CYC  = cyc_up(T_INIT_NS);

   // counter load values: interval lasts load+1 cycles
   localparam logic [CNT_W-1:0] RP_LD    = CNT_W'(RP_CYC - 1);
   localparam logic [CNT_W-1:0] RCD_LD   = CNT_W'(RCD_CYC - 1);
   localparam logic [CNT_W-1:0] MRR_LD   = CNT_W'(MRR_CYC - 1);
   localparam logic [CNT_W-1:0] MRW_LD   = CNT_W'(MRW_CYC - 1);
   localparam logic [CNT_W-1:0] BURST_LD = CNT_W'(BURST_CYC - 1);
   localparam logic [CNT_W-1:0] INIT_LD  = CNT_W'(INIT_CYC - 1);

   // mode-register address whose write acts as device reset
   localparam logic [MA_W-1:0] RESET_MA = 8'hFF;

   // ---------------------------------------------------------------
   // enumerations
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_NOP  = 4'h0,
      CMD_ACT  = 4'h1,
      CMD_RD   = 4'h2,
      CMD_WR   = 4'h3,
      CMD_PRE  = 4'h4,
      CMD_PREA = 4'h5,
      CMD_MRR  = 4'h6,
      CMD_MRW  = 4'h7,
      CMD_BST  = 4'h8
   } lbt_cmd_type;

   typedef enum logic [BS_W-1:0] {
      BS_IDLE, BS_ACTIVATING, BS_ACTIVE, BS_READING,
      BS_WRITING, BS_READ_AP, BS_WRITE_AP, BS_PRECHARGING
   } lbt_bank_state_type;

   typedef enum logic [3:0] {
      BC_NOP, BC_ACT, BC_RD, BC_RDA, BC_WR, BC_WRA, BC_PRE, BC_END, BC_CLEAR
   } lbt_bank_cmd_type;

   typedef enum logic [2:0] {
      DS_POWER_ON, DS_RESETTING, DS_READY, DS_MRR_IDLE,
      DS_MRR_ACTIVE, DS_MRR_RESET, DS_MRW, DS_PREALL
   } lbt_dev_state_type;

endpackage

// ---- hdl/lbt_tracker.sv ----
/*
 * lbt_tracker: device-level command decode and bank tracking for an
 * LPDDR2 memory device, one lbt_bank per bank.
 * Assumes commands arrive on CORE_CLK from controller logic in the
 * same domain, one per cycle, CMD_NOP when nothing is sent.
 */
// Operation
// - MRR with all banks idle holds idle MR reading for tMRR, then idle.
// - MRR during resetting holds resetting MR reading for tMRR, then idle.
// - MRR with an open row holds active MR reading, banks stay active.
// - MRW holds MR writing for tMRW, then all banks idle.
// - precharge-all lasts tRP, then every bank is idle.
// - precharged bank goes idle only after tRP.
// - activated bank becomes active only after tRCD.
// - read with auto precharge keeps bank busy tRP, then idle.
// - write with auto precharge keeps bank busy tRP, then idle.
// - precharging an idle bank still starts tRP.
// - new read or write to another bank may carry auto precharge or not.
// - burst terminate ends the most recent burst, any bank.
// - with bank n idle, bank m follows its own transitions.
// - MRR with banks open, activating or precharging enters active MR reading, never idle MR reading.
// - during a burst, other banks accept activate, precharge, and a read or write in the burst's direction.
// - device reset is a mode-register write to one address.
// - reading or writing only from bursts without auto precharge.
`timescale 1ns/10ps
module lbt_tracker import lbt_pkg::*; (
   input  logic                        CORE_CLK,
   input  logic                        RESET,
   input  lbt_cmd_type                 CMD,
   input  logic [BANK_W-1:0]           CMD_BANK,
   input  logic                        CMD_AP,
   input  logic [MA_W-1:0]             CMD_MA,
   output logic [NUM_BANKS*BS_W-1:0]   BANK_STATE,
   output lbt_dev_state_type           DEV_STATE,
   output logic                        ALL_IDLE,
   output logic                        BURST_ACTIVE,
   output logic                        ILLEGAL_CMD
);

   lbt_bank_state_type bst  [NUM_BANKS];
   lbt_bank_cmd_type   bcmd [NUM_BANKS];
   lbt_dev_state_type  dev_q, dev_d;
   logic [CNT_W-1:0]   dcnt_q, dcnt_d;
   logic [CNT_W-1:0]   bcnt_q, bcnt_d;
   logic [BANK_W-1:0]  last_q, last_d;
   logic               run_q, run_d;
   logic               lrd_q, lrd_d;
   logic               ill_q, illegal_d;
   logic               go_rst;
   logic               all_idle, prea_ok, ap_busy;
   logic               tgt_busy, tgt_open, rd_cmd;
   lbt_bank_state_type tgt;

   // ---------------------------------------------------------------
   // banks, each on its own transitions
   // ---------------------------------------------------------------
   lbt_bank_if bif [NUM_BANKS] ();
   for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
      assign bif[i].cmd = bcmd[i];
      assign bst[i] = bif[i].state;
      assign BANK_STATE[i*BS_W +: BS_W] = bif[i].state;
      lbt_bank u_bank (
         .clk (CORE_CLK),
         .rst (RESET),
         .bif (bif[i])
      );
   end

   // summary of all banks
   always_comb begin
      all_idle = 1'b1;
      prea_ok  = 1'b1;
      ap_busy  = 1'b0;
      for (int i = 0; i < NUM_BANKS; i++) begin
         if (bst[i] != BS_IDLE) all_idle = 1'b0;
         if (!(bst[i] inside {BS_IDLE, BS_ACTIVE, BS_READING, BS_WRITING})) begin
            prea_ok = 1'b0;
         end
         if (bst[i] inside {BS_READ_AP, BS_WRITE_AP}) ap_busy = 1'b1;
      end
   end

   // addressed bank
   assign tgt      = bst[CMD_BANK];
   assign tgt_busy = tgt inside {BS_ACTIVATING, BS_PRECHARGING, BS_READ_AP, BS_WRITE_AP};
   assign tgt_open = tgt inside {BS_ACTIVE, BS_READING, BS_WRITING};
   assign rd_cmd   = (CMD == CMD_RD);

   // ---------------------------------------------------------------
   // device decode: next values of device, burst and flag state
   // ---------------------------------------------------------------
   always_comb begin
      dev_d     = dev_q;
      dcnt_d    = dcnt_q;
      run_d     = run_q;
      bcnt_d    = bcnt_q;
      last_d    = last_q;
      lrd_d     = lrd_q;
      illegal_d = 1'b0;
      go_rst    = 1'b0;
      for (int i = 0; i < NUM_BANKS; i++) bcmd[i] = BC_NOP;
      if (dcnt_q != '0) dcnt_d = dcnt_q - 1'b1;
      // interval end returns the device to normal decode
      if (dcnt_q == '0 && dev_q != DS_POWER_ON && dev_q != DS_READY) begin
         dev_d = DS_READY;
         if (dev_q == DS_MRW || dev_q == DS_MRR_RESET) begin
            for (int i = 0; i < NUM_BANKS; i++) bcmd[i] = BC_CLEAR;
         end
      end
      // natural end of the running burst
      if (run_q) begin
         if (bcnt_q == '0) begin
            run_d        = 1'b0;
            bcmd[last_q] = BC_END;
         end else begin
            bcnt_d = bcnt_q - 1'b1;
         end
      end
      case (dev_q)
         DS_POWER_ON: begin
            if (CMD == CMD_MRW && CMD_MA == RESET_MA) go_rst = 1'b1;
            else if (CMD != CMD_NOP) illegal_d = 1'b1;
         end
         DS_RESETTING: begin
            if (CMD == CMD_MRR) begin
               dev_d  = DS_MRR_RESET;
               dcnt_d = MRR_LD;
            end else if (CMD != CMD_NOP) begin
               illegal_d = 1'b1;
            end
         end
         DS_READY: begin
            case (CMD)
               CMD_NOP: ;
               CMD_ACT: begin
                  if (tgt == BS_IDLE) bcmd[CMD_BANK] = BC_ACT;
                  else illegal_d = 1'b1;
               end
               CMD_RD, CMD_WR: begin
                  // a read-write turnaround needs the burst finished first
                  if (tgt_open && !(run_q && lrd_q != rd_cmd)) begin
                     if (run_q && last_q != CMD_BANK) bcmd[last_q] = BC_END;
                     if (rd_cmd) bcmd[CMD_BANK] = CMD_AP ? BC_RDA : BC_RD;
                     else bcmd[CMD_BANK] = CMD_AP ? BC_WRA : BC_WR;
                     run_d  = 1'b1;
                     bcnt_d = BURST_LD;
                     last_d = CMD_BANK;
                     lrd_d  = rd_cmd;
                  end else begin
                     illegal_d = 1'b1;
                  end
               end
               CMD_PRE: begin
                  if (!tgt_busy) begin
                     bcmd[CMD_BANK] = BC_PRE;
                     if (run_q && last_q == CMD_BANK) run_d = 1'b0;
                  end else begin
                     illegal_d = 1'b1;
                  end
               end
               CMD_PREA: begin
                  if (prea_ok) begin
                     for (int i = 0; i < NUM_BANKS; i++) bcmd[i] = BC_PRE;
                     dev_d  = DS_PREALL;
                     dcnt_d = RP_LD;
                     run_d  = 1'b0;
                  end else begin
                     illegal_d = 1'b1;
                  end
               end
               CMD_MRR: begin
                  if (!run_q && !ap_busy) begin
                     dev_d  = all_idle ? DS_MRR_IDLE : DS_MRR_ACTIVE;
                     dcnt_d = MRR_LD;
                  end else begin
                     illegal_d = 1'b1;
                  end
               end
               CMD_MRW: begin
                  if (all_idle && !run_q) begin
                     if (CMD_MA == RESET_MA) begin
                        go_rst = 1'b1;
                     end else begin
                        dev_d  = DS_MRW;
                        dcnt_d = MRW_LD;
                     end
                  end else begin
                     illegal_d = 1'b1;
                  end
               end
               CMD_BST: begin
                  if (run_q) begin
                     bcmd[last_q] = BC_END;
                     run_d        = 1'b0;
                  end else begin
                     illegal_d = 1'b1;
                  end
               end
               default: illegal_d = 1'b1;
            endcase
         end
         // protected intervals: anything but NOP is refused
         default: begin
            if (CMD != CMD_NOP) illegal_d = 1'b1;
         end
      endcase
      if (go_rst) begin
         dev_d  = DS_RESETTING;
         dcnt_d = INIT_LD;
         run_d  = 1'b0;
         for (int i = 0; i < NUM_BANKS; i++) bcmd[i] = BC_CLEAR;
      end
   end

   // registers
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         dev_q  <= DS_POWER_ON;
         dcnt_q <= '0;
         run_q  <= 1'b0;
         bcnt_q <= '0;
         last_q <= '0;
         lrd_q  <= 1'b0;
         ill_q  <= 1'b0;
      end else begin
         dev_q  <= dev_d;
         dcnt_q <= dcnt_d;
         run_q  <= run_d;
         bcnt_q <= bcnt_d;
         last_q <= last_d;
         lrd_q  <= lrd_d;
         ill_q  <= illegal_d;
      end
   end

   assign DEV_STATE    = dev_q;
   assign ALL_IDLE     = all_idle && (dev_q == DS_READY);
   assign BURST_ACTIVE = run_q;
   assign ILLEGAL_CMD  = ill_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   localparam int A_MRR = MRR_CYC;
   localparam int A_MRW = MRW_CYC;
   localparam int A_RP  = RP_CYC;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);

   property p_mrr_idle;
      (dev_q == DS_READY && CMD == CMD_MRR && !illegal_d && all_idle)
         |=> (dev_q == DS_MRR_IDLE) ##A_MRR (dev_q == DS_READY && all_idle);
   endproperty
   a_mrr_idle: assert property (p_mrr_idle) else $error("idle MRR wrong");

   property p_mrr_reset;
      (dev_q == DS_RESETTING && CMD == CMD_MRR)
         |=> (dev_q == DS_MRR_RESET) ##A_MRR (dev_q == DS_READY && all_idle);
   endproperty
   a_mrr_reset: assert property (p_mrr_reset) else $error("resetting MRR wrong");

   property p_mrr_active;
      (dev_q == DS_READY && CMD == CMD_MRR && !illegal_d && tgt == BS_ACTIVE)
         |=> (dev_q == DS_MRR_ACTIVE) ##A_MRR (dev_q == DS_READY && !all_idle);
   endproperty
   a_mrr_active: assert property (p_mrr_active) else $error("active MRR wrong");

   property p_mrw;
      (dev_q == DS_READY && CMD == CMD_MRW && !illegal_d && CMD_MA != RESET_MA)
         |=> (dev_q == DS_MRW) ##A_MRW (dev_q == DS_READY && all_idle);
   endproperty
   a_mrw: assert property (p_mrw) else $error("MRW interval wrong");

   property p_prea;
      (dev_q == DS_READY && CMD == CMD_PREA && !illegal_d)
         |=> (dev_q == DS_PREALL) ##A_RP (dev_q == DS_READY && all_idle);
   endproperty
   a_prea: assert property (p_prea) else $error("precharge all wrong");

   property p_bst;
      (dev_q == DS_READY && CMD == CMD_BST && run_q
         && bst[last_q] inside {BS_READING, BS_WRITING})
         |=> (bst[$past(last_q)] == BS_ACTIVE && !run_q);
   endproperty
   a_bst: assert property (p_bst) else $error("burst terminate missed");

   property p_turnaround;
      (dev_q == DS_READY && (CMD == CMD_WR || CMD == CMD_RD) && run_q
         && lrd_q != (CMD == CMD_RD)) |=> ILLEGAL_CMD;
   endproperty
   a_turnaround: assert property (p_turnaround) else $error("turnaround not flagged");

   property p_illegal;
      illegal_d |-> (bcmd[CMD_BANK] inside {BC_NOP, BC_END, BC_CLEAR}) ##1 ILLEGAL_CMD;
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal command acted on");

   c_mrr_active: cover property (dev_q == DS_MRR_ACTIVE ##1 dev_q == DS_READY);
   c_prea: cover property (dev_q == DS_PREALL ##1 dev_q == DS_READY);
   c_bst: cover property (dev_q == DS_READY && CMD == CMD_BST && !illegal_d);
   c_ap_other: cover property (ap_busy && CMD == CMD_RD && !illegal_d);

endmodule

// ---- sim/lbt_bank_state_tracker_test.sv ----
/*
 * lbt_bank_state_tracker_test: self-checking bench for lbt_tracker.
 * Assumes package counts and a 50 ns core clock.
 */
`timescale 1ns/10ps
module lbt_bank_state_tracker_test import lbt_pkg::*; ;
   logic                       clk;
   logic                       reset;
   lbt_cmd_type                cmd;
   logic [BANK_W-1:0]          bnk;
   logic                       ap;
   logic [MA_W-1:0]            ma;
   logic [NUM_BANKS*BS_W-1:0]  bank_state;
   lbt_dev_state_type          dev_state;
   logic                       all_idle;
   logic                       burst_active;
   logic                       illegal_cmd;
   int                         n_errors;
   int                         checked;
   int                         mb[NUM_BANKS];
   int                         md;
   int                         b;
   int                         c;
   logic [31:0]                lfsr;

   lbt_ctrl_model ctl (.clk(clk), .cmd(cmd), .bank(bnk), .ap(ap), .ma(ma));
   lbt_tracker uut (.CORE_CLK(clk), .RESET(reset), .CMD(cmd), .CMD_BANK(bnk),
      .CMD_AP(ap), .CMD_MA(ma), .BANK_STATE(bank_state), .DEV_STATE(dev_state),
      .ALL_IDLE(all_idle), .BURST_ACTIVE(burst_active), .ILLEGAL_CMD(illegal_cmd));

   // 50 ns clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic span(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // whole model against the ports; all_idle derived, not read back
   task automatic cmp_all();
      logic ai;
      ai = (md == DS_READY);
      for (int i = 0; i < NUM_BANKS; i++) begin
         check("bank_state", 8'(bank_state[i*BS_W+:BS_W]), 8'(mb[i]));
         ai = ai && (mb[i] == 0);
      end
      check("dev_state", 8'(dev_state), 8'(md));
      check("all_idle", 8'(all_idle), 8'(ai));
   endtask

   // bk below zero means every bank, beyond the last means none
   task automatic put(input int bk, input int v, input int d);
      for (int i = 0; i < NUM_BANKS; i++) begin
         if (bk < 0 || bk == i) begin
            mb[i] = v;
         end
      end
      md = d;
   endtask

   // timed interval: busy through cycle n, done at cycle n+1
   task automatic run(input lbt_cmd_type k, input int bk, input logic a,
                      input int n, input int bb, input int bd, input int db,
                      input int dd);
      ctl.issue(k, bk, a, 8'h00);
      put(bk, bb, db);
      cmp_all();
      span(n - 1);
      cmp_all();
      span(1);
      put(bk, bd, dd);
      cmp_all();
   endtask

   task automatic results();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // watchdog, well past the fewer than one hundred cycles the run needs
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      results();
   end

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      reset = 1'b1;
      n_errors = 0;
      checked = 0;
      lfsr = step(32'h9976);
      b = int'(lfsr[2:0]);
      c = (b + 1 + int'(lfsr[4:3])) % NUM_BANKS;
      put(-1, BS_IDLE, DS_POWER_ON);
      repeat (16) @(posedge clk);
      #1;
      reset = 1'b0;
      cmp_all();
      ctl.issue(CMD_ACT, b, 1'b0, 8'h00);
      check("illegal_cmd", 8'(illegal_cmd), 8'h01);
      cmp_all();
      ctl.issue(CMD_MRW, 0, 1'b0, RESET_MA);
      md = DS_RESETTING;
      cmp_all();
      run(CMD_MRR, 8, 1'b0, MRR_CYC, 0, 0, DS_MRR_RESET, DS_READY);
      run(CMD_MRR, 8, 1'b0, MRR_CYC, 0, 0, DS_MRR_IDLE, DS_READY);
      run(CMD_ACT, b, 1'b0, RCD_CYC, BS_ACTIVATING, BS_ACTIVE, DS_READY, DS_READY);
      run(CMD_MRR, b, 1'b0, MRR_CYC, BS_ACTIVE, BS_ACTIVE, DS_MRR_ACTIVE, DS_READY);
      ctl.issue(CMD_RD, b, 1'b0, 8'h00);
      mb[b] = BS_READING;
      cmp_all();
      check("burst_active", 8'(burst_active), 8'h01);
      ctl.issue(CMD_BST, 0, 1'b0, 8'h00);
      mb[b] = BS_ACTIVE;
      cmp_all();
      run(CMD_ACT, c, 1'b0, RCD_CYC, BS_ACTIVATING, BS_ACTIVE, DS_READY, DS_READY);
      ctl.issue(CMD_RD, b, 1'b0, 8'h00);
      mb[b] = BS_READING;
      cmp_all();
      mb[b] = BS_ACTIVE;
      run(CMD_RD, c, 1'b1, RP_CYC, BS_READ_AP, BS_IDLE, DS_READY, DS_READY);
      // the burst outlives the auto-precharge interval on its own count
      span(BURST_CYC - RP_CYC - 1);
      check("burst_active", 8'(burst_active), 8'h01);
      span(1);
      check("burst_active", 8'(burst_active), 8'h00);
      run(CMD_WR, b, 1'b1, RP_CYC, BS_WRITE_AP, BS_IDLE, DS_READY, DS_READY);
      run(CMD_PRE, c, 1'b0, RP_CYC, BS_PRECHARGING, BS_IDLE, DS_READY, DS_READY);
      run(CMD_ACT, b, 1'b0, RCD_CYC, BS_ACTIVATING, BS_ACTIVE, DS_READY, DS_READY);
      // plain write: a read inside its burst is refused, then it ends by itself
      ctl.issue(CMD_WR, b, 1'b0, 8'h00);
      mb[b] = BS_WRITING;
      ctl.issue(CMD_RD, b, 1'b0, 8'h00);
      check("illegal_cmd", 8'(illegal_cmd), 8'h01);
      cmp_all();
      span(BURST_CYC - 3);
      cmp_all();
      span(1);
      mb[b] = BS_ACTIVE;
      cmp_all();
      check("burst_active", 8'(burst_active), 8'h00);
      run(CMD_PREA, -1, 1'b0, RP_CYC, BS_PRECHARGING, BS_IDLE, DS_PREALL, DS_READY);
      span(BURST_CYC);
      ctl.issue(CMD_MRW, 0, 1'b0, {1'b0, lfsr[14:8]});
      md = DS_MRW;
      cmp_all();
      ctl.issue(CMD_ACT, b, 1'b0, 8'h00);
      check("illegal_cmd", 8'(illegal_cmd), 8'h01);
      cmp_all();
      span(MRW_CYC - 3);
      cmp_all();
      span(1);
      md = DS_READY;
      cmp_all();
      // device reset from the ready state, all banks idle
      ctl.issue(CMD_MRW, 0, 1'b0, RESET_MA);
      md = DS_RESETTING;
      cmp_all();
      results();
   end
endmodule

// ---- sim/lbt_ctrl_model.sv ----
/*
 * lbt_ctrl_model: controller that sends commands to the tracker.
 * Assumes the bench calls issue() and shares the core clock.
 */
`timescale 1ns/10ps
module lbt_ctrl_model import lbt_pkg::*; (
   input  wire logic          clk,
   output lbt_cmd_type        cmd,
   output logic [BANK_W-1:0]  bank,
   output logic               ap,
   output logic [MA_W-1:0]    ma
);
   // idle is NOP from time zero
   initial begin
      cmd = CMD_NOP;
      bank = '0;
      ap = 1'b0;
      ma = '0;
   end

   // one command held for one edge, then NOP; stale bank and ma fields are
   // inverted so the tracker cannot lean on leftovers
   task automatic issue(input lbt_cmd_type c, input int b, input logic a,
                        input logic [MA_W-1:0] m);
      @(posedge clk);
      #1;
      cmd = c;
      bank = BANK_W'(b);
      ap = a;
      ma = m;
      @(posedge clk);
      #1;
      cmd = CMD_NOP;
      bank = ~bank;
      ma = ~ma;
   endtask
endmodule
